// ### ptp_clock_ts.sv
// ptp time-of-day clock, compare events, gpio and frame timestamps
`timescale 1ns/100ps
`default_nettype none
`include "ptp_defines.svh"
module ptp_clock_ts
  import ptp_pkg::*;
#(
  parameter int CH = 2,
  parameter int FRAC_W = 16,
  parameter int PULSE_CYC = `PTP_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // clock tuning and load
  input wire logic tune_en,
  input wire logic [7:0] tune_ns,
  input wire logic [FRAC_W-1:0] tune_frac,
  input wire logic time_load,
  input wire ptp_time_t time_load_val,
  output ptp_time_t time_now,
  // compare channels
  input wire ptp_time_t cmp_target [CH],
  input wire logic [CH-1:0] cmp_arm,
  input wire logic [CH-1:0] cmp_disarm,
  output logic [CH-1:0] cmp_armed,
  // gpio configuration
  input wire logic [CH-1:0] gpio_cfg_in,
  input wire logic [CH-1:0] gpio_cfg_rise,
  input wire logic [CH-1:0] gpio_cfg_fall,
  input wire ptp_gpo_t gpio_cfg_out [CH],
  // gpio pins and captures
  input wire logic [CH-1:0] gpio_i,
  output logic [CH-1:0] gpio_o,
  output logic [CH-1:0] gpio_oe_n,
  output ptp_time_t gpio_cap_time [CH],
  // frame path configuration
  input wire ptp_role_t cfg_role,
  input wire ptp_dly_t cfg_dly,
  input wire logic cfg_one_step,
  // frame path
  input wire ptp_msg_t msg_in,
  output ptp_ts_t ts_out,
  output ptp_ins_t ins_out,
  output logic msg_bad,
  // interrupt status and mask
  input wire logic [2*CH+1:0] irq_mask,
  input wire logic [2*CH+1:0] irq_clr,
  output logic [2*CH+1:0] irq_status,
  output logic irq
);
  localparam int SRC = 2 * CH + 2;

  // ************************************************
  // time-of-day clock
  // ************************************************
  logic [31:0] sec_r, sec_nxt;
  logic [29:0] ns_r, ns_nxt;
  logic [FRAC_W-1:0] frac_r, frac_nxt;
  logic [FRAC_W:0] frac_sum;
  logic [30:0] ns_sum;
  logic [7:0] step_ns;

  // nominal step or tuned step with fractional carry
  always_comb begin
    step_ns = tune_en ? tune_ns : 8'(`PTP_CLK_PERIOD_NS);
    frac_sum = {1'b0, frac_r} + {1'b0, tune_frac & {FRAC_W{tune_en}}};
    ns_sum = {1'b0, ns_r} + {23'h0, step_ns} + {30'h0, frac_sum[FRAC_W]};
    frac_nxt = frac_sum[FRAC_W-1:0];
    sec_nxt = sec_r;
    ns_nxt = ns_sum[29:0];
    if (time_load) begin
      sec_nxt = time_load_val.sec;
      ns_nxt = (time_load_val.ns > `PTP_NS_MAX) ? 30'h0 : time_load_val.ns;
      frac_nxt = '0;
    end else if (ns_sum > {1'b0, `PTP_NS_MAX}) begin
      ns_nxt = 30'(ns_sum - `PTP_NS_WRAP);
      sec_nxt = sec_r + 32'h1;
    end
  end

  // register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sec_r <= 32'h0;
      ns_r <= 30'h0;
      frac_r <= '0;
    end else begin
      sec_r <= sec_nxt;
      ns_r <= ns_nxt;
      frac_r <= frac_nxt;
    end
  end

  // one time base for every function
  assign time_now = '{sec: sec_r, ns: ns_r};

  // nanoseconds never leave the legal range, whatever the step
  ns_range_a: assert property (@(posedge core_clk) disable iff (srst)
    ns_r <= `PTP_NS_MAX) else $error("nanoseconds out of range");
  // a load lands on the next edge, a nanosecond value past the maximum loading as zero
  load_sec_a: assert property (@(posedge core_clk) disable iff (srst)
    time_load |=> time_now.sec == $past(time_load_val.sec)) else $error("seconds not loaded");
  load_ns_a: assert property (@(posedge core_clk) disable iff (srst)
    time_load && time_load_val.ns <= `PTP_NS_MAX |=> time_now.ns == $past(time_load_val.ns))
    else $error("nanoseconds not loaded");
  sec_carry_a: assert property (@(posedge core_clk) disable iff (srst)
    !time_load && ns_sum > {1'b0, `PTP_NS_MAX} |=> sec_r == $past(sec_r) + 32'h1
    && ns_r < 30'h100) else $error("seconds did not carry");

  // ************************************************
  // compare channels and gpio pins
  // ************************************************
  logic [CH-1:0] cmp_hit, cap_valid;
  logic [SRC-1:0] status_r, status_nxt, src_set;
  logic irq_r, irq_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < CH; gi++) begin : g_ch
      ptp_cmp_unit u_cmp (
        .core_clk(core_clk),
        .srst(srst),
        .now(time_now),
        .target(cmp_target[gi]),
        .arm(cmp_arm[gi]),
        .disarm(cmp_disarm[gi]),
        .hit(cmp_hit[gi]),
        .armed(cmp_armed[gi])
      );
      ptp_gpio_pin #(.PULSE_CYC(PULSE_CYC)) u_gpio (
        .core_clk(core_clk),
        .srst(srst),
        .cfg_in(gpio_cfg_in[gi]),
        .cfg_rise(gpio_cfg_rise[gi]),
        .cfg_fall(gpio_cfg_fall[gi]),
        .cfg_out(gpio_cfg_out[gi]),
        .pin_i(gpio_i[gi]),
        .pin_o(gpio_o[gi]),
        .pin_oe_n(gpio_oe_n[gi]),
        .now(time_now),
        .cmp_hit(cmp_hit[gi]),
        .irq_lvl(status_r[gi]),
        .cap_valid(cap_valid[gi]),
        .cap_time(gpio_cap_time[gi])
      );
    end
  endgenerate

  // ************************************************
  // frame path timestamps
  // ************************************************
  ptp_ts_t ts_r, ts_nxt;
  ptp_ins_t ins_r, ins_nxt;
  logic bad_r, bad_nxt;
  logic known, syncrel, xmit, stamp, ins;

  // classify, pick what to stamp, request insertion
  always_comb begin
    known = 1'b0;
    syncrel = 1'b0;
    case (msg_in.mtype)
      `PTP_MT_SYNC, `PTP_MT_DLY_REQ, `PTP_MT_PDLY_REQ, `PTP_MT_PDLY_RSP,
      `PTP_MT_FOLLOW, `PTP_MT_DLY_RSP, `PTP_MT_PDLY_FUP: begin
        known = 1'b1;
        syncrel = 1'b1;
      end
      `PTP_MT_ANNOUNCE, `PTP_MT_SIGNAL, `PTP_MT_MGMT: known = 1'b1;
      default: known = 1'b0;
    endcase
    xmit = (cfg_role == PTP_ROLE_XMIT);
    stamp = 1'b0;
    if (msg_in.valid && syncrel) begin
      case (msg_in.mtype)
        `PTP_MT_SYNC: stamp = (msg_in.tx == xmit);
        `PTP_MT_DLY_REQ: stamp = (cfg_dly == PTP_DLY_E2E) && (msg_in.tx != xmit);
        `PTP_MT_PDLY_REQ, `PTP_MT_PDLY_RSP: stamp = (cfg_dly == PTP_DLY_P2P);
        default: stamp = 1'b0;
      endcase
    end
    ins = stamp && msg_in.tx && cfg_one_step
      && (msg_in.mtype == `PTP_MT_SYNC || msg_in.mtype == `PTP_MT_PDLY_RSP);
    ts_nxt = '{valid: stamp, tx: msg_in.tx, mtype: msg_in.mtype, stamp: time_now};
    ins_nxt = '{valid: ins, stamp: time_now};
    bad_nxt = msg_in.valid && !known;
  end

  // register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ts_r <= '0;
      ins_r <= '0;
      bad_r <= 1'b0;
    end else begin
      ts_r <= ts_nxt;
      ins_r <= ins_nxt;
      bad_r <= bad_nxt;
    end
  end

  assign ts_out = ts_r;
  assign ins_out = ins_r;
  assign msg_bad = bad_r;

  role_sync_a: assert property (@(posedge core_clk) disable iff (srst)
    msg_in.valid && msg_in.mtype == `PTP_MT_SYNC && msg_in.tx == (cfg_role == PTP_ROLE_XMIT)
    |=> ts_out.valid && ts_out.stamp == $past(time_now)) else $error("sync not stamped");
  e2e_no_pdly_a: assert property (@(posedge core_clk) disable iff (srst)
    cfg_dly == PTP_DLY_E2E && (msg_in.mtype == `PTP_MT_PDLY_REQ || msg_in.mtype == `PTP_MT_PDLY_RSP)
    |=> !ts_out.valid) else $error("peer message stamped in e2e");
  bad_type_a: assert property (@(posedge core_clk) disable iff (srst)
    msg_in.valid && msg_in.mtype inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hE, 4'hF}
    |=> msg_bad && !ts_out.valid) else $error("unknown type not flagged");
  one_step_a: assert property (@(posedge core_clk) disable iff (srst)
    msg_in.valid && msg_in.tx && msg_in.mtype == `PTP_MT_SYNC && cfg_role == PTP_ROLE_XMIT
    |=> ins_out.valid == $past(cfg_one_step)) else $error("one-step insert wrong");

  // ************************************************
  // interrupt status and mask
  // ************************************************
  // sticky status, a new event beats a clear
  always_comb begin
    src_set = {ts_nxt.valid && !msg_in.tx, ts_nxt.valid && msg_in.tx, cap_valid, cmp_hit};
    status_nxt = (status_r & ~irq_clr) | src_set;
    irq_nxt = |(status_nxt & irq_mask);
  end

  // register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq_status = status_r;
  assign irq = irq_r;

  cmp_irq_a: assert property (@(posedge core_clk) disable iff (srst)
    cmp_hit[0] |=> irq_status[0] ##1 (irq_status[0] || $past(irq_clr[0]))) else $error("compare irq lost");
  irq_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 irq == |(irq_status & $past(irq_mask))) else $error("irq not gated by mask");

  // ************************************************
  // status source checks
  // ************************************************
  // a capture reaches its own status bit one edge after the capture
  cap_status_a: assert property (@(posedge core_clk) disable iff (srst)
    cap_valid[0] |=> irq_status[CH]) else $error("capture status lost");
  // stamped frames mark their direction in status
  tx_status_a: assert property (@(posedge core_clk) disable iff (srst)
    ts_nxt.valid && msg_in.tx |=> irq_status[2*CH]) else $error("tx stamp status lost");
  rx_status_a: assert property (@(posedge core_clk) disable iff (srst)
    ts_nxt.valid && !msg_in.tx |=> irq_status[2*CH+1]) else $error("rx stamp status lost");
  // a clear with no new event empties the bit
  clr_status_a: assert property (@(posedge core_clk) disable iff (srst)
    irq_clr[0] && !cmp_hit[0] |=> !irq_status[0]) else $error("status not cleared");
  // an insertion always comes with a stamp of the same frame
  ins_stamped_a: assert property (@(posedge core_clk) disable iff (srst)
    ins_out.valid |-> ts_out.valid && ts_out.tx) else $error("insert without stamp");
endmodule
`default_nettype wire

// ### ptp_defines.svh
// constants for the ptp clock and timestamp unit
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH

// ************************************************
// clock rate and time base
// ************************************************
`define PTP_CLK_MHZ 20
`define PTP_CLK_PERIOD_NS (1000 / `PTP_CLK_MHZ)
`define PTP_NS_MAX 30'h3B9AC9FF
`define PTP_NS_WRAP 31'h3B9ACA00

// ************************************************
// gpio pulse width, least time rounded up
// ************************************************
`define PTP_PULSE_NS 1000
`define PTP_PULSE_CYC ((`PTP_PULSE_NS + `PTP_CLK_PERIOD_NS - 1) / `PTP_CLK_PERIOD_NS)

// ************************************************
// message type codes
// ************************************************
`define PTP_MT_SYNC 4'h0
`define PTP_MT_DLY_REQ 4'h1
`define PTP_MT_PDLY_REQ 4'h2
`define PTP_MT_PDLY_RSP 4'h3
`define PTP_MT_FOLLOW 4'h8
`define PTP_MT_DLY_RSP 4'h9
`define PTP_MT_PDLY_FUP 4'hA
`define PTP_MT_ANNOUNCE 4'hB
`define PTP_MT_SIGNAL 4'hC
`define PTP_MT_MGMT 4'hD

`endif

// ### ptp_pkg.sv
// types for the ptp clock and timestamp unit
`default_nettype none
package ptp_pkg;
  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } ptp_time_t;
  typedef struct packed {
    logic valid;
    logic tx;
    logic [3:0] mtype;
  } ptp_msg_t;
  typedef struct packed {
    logic valid;
    logic tx;
    logic [3:0] mtype;
    ptp_time_t stamp;
  } ptp_ts_t;
  typedef struct packed {
    logic valid;
    ptp_time_t stamp;
  } ptp_ins_t;
  typedef enum logic {PTP_ROLE_RECV, PTP_ROLE_XMIT} ptp_role_t;
  typedef enum logic {PTP_DLY_E2E, PTP_DLY_P2P} ptp_dly_t;
  typedef enum logic [1:0] {PTP_GO_TOGGLE, PTP_GO_PULSE, PTP_GO_IRQ, PTP_GO_LOW} ptp_gpo_t;
endpackage
`default_nettype wire

// ### ptp_cmp_unit.sv
// compare channel: one hit when the clock reaches its target
`timescale 1ns/100ps
`default_nettype none
module ptp_cmp_unit
  import ptp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // time and target
  input wire ptp_time_t now,
  input wire ptp_time_t target,
  input wire logic arm,
  input wire logic disarm,
  // result
  output logic hit,
  output logic armed
);
  logic armed_r, armed_nxt;
  logic reach;

  // reached when the whole time is at or past target
  assign reach = {now.sec, now.ns} >= {target.sec, target.ns};
  assign hit = armed_r && reach;
  assign armed = armed_r;

  // a hit or disarm clears, arm wins
  always_comb begin
    armed_nxt = armed_r;
    if (hit || disarm) begin
      armed_nxt = 1'b0;
    end
    if (arm) begin
      armed_nxt = 1'b1;
    end
  end

  // register
  always_ff @(posedge core_clk) begin
    armed_r <= srst ? 1'b0 : armed_nxt;
  end

  cmp_one_shot_a: assert property (@(posedge core_clk) disable iff (srst)
    hit && !arm |=> !armed_r && !hit) else $error("compare hit did not disarm");
endmodule
`default_nettype wire

// ### ptp_gpio_pin.sv
// one gpio pin: time capture on input, compare signal on output
`timescale 1ns/100ps
`default_nettype none
`include "ptp_defines.svh"
module ptp_gpio_pin
  import ptp_pkg::*;
#(
  parameter int PULSE_CYC = `PTP_PULSE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // configuration
  input wire logic cfg_in,
  input wire logic cfg_rise,
  input wire logic cfg_fall,
  input wire ptp_gpo_t cfg_out,
  // pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n,
  // time, compare and interrupt status
  input wire ptp_time_t now,
  input wire logic cmp_hit,
  input wire logic irq_lvl,
  // capture
  output logic cap_valid,
  output ptp_time_t cap_time
);
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic prev_r, prev_nxt, pin_r, pin_nxt, capv_r, capv_nxt, ev;
  logic [CW-1:0] cnt_r, cnt_nxt;
  ptp_time_t cap_r, cap_nxt;

  // edge capture and output drive
  always_comb begin
    prev_nxt = pin_i;
    ev = cfg_in && ((cfg_rise && pin_i && !prev_r) || (cfg_fall && !pin_i && prev_r));
    capv_nxt = ev;
    cap_nxt = ev ? now : cap_r;
    cnt_nxt = '0;
    pin_nxt = 1'b0;
    case (cfg_out)
      PTP_GO_TOGGLE: pin_nxt = cmp_hit ? !pin_r : pin_r;
      PTP_GO_PULSE: begin
        cnt_nxt = cmp_hit ? CW'(PULSE_CYC - 1) : (cnt_r != '0 ? cnt_r - 1'b1 : cnt_r);
        pin_nxt = cmp_hit || (cnt_r != '0);
      end
      PTP_GO_IRQ: pin_nxt = irq_lvl;
      default: pin_nxt = 1'b0;
    endcase
  end

  // register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_r <= 1'b0;
      pin_r <= 1'b0;
      capv_r <= 1'b0;
      cnt_r <= '0;
      cap_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      pin_r <= pin_nxt;
      capv_r <= capv_nxt;
      cnt_r <= cnt_nxt;
      cap_r <= cap_nxt;
    end
  end

  assign pin_o = pin_r;
  assign pin_oe_n = cfg_in; // driven only as an output
  assign cap_valid = capv_r;
  assign cap_time = cap_r;

  cap_time_a: assert property (@(posedge core_clk) disable iff (srst)
    ev |=> cap_valid && cap_time == $past(now)) else $error("capture time wrong");
  toggle_out_a: assert property (@(posedge core_clk) disable iff (srst)
    cfg_out == PTP_GO_TOGGLE && cmp_hit |=> pin_o != $past(pin_o)) else $error("no toggle on hit");
  irq_pin_a: assert property (@(posedge core_clk) disable iff (srst)
    cfg_out == PTP_GO_IRQ |=> pin_o == $past(irq_lvl)) else $error("pin not showing status");
endmodule
`default_nettype wire

// ### ptp_mac_model.sv
// far-side model: mac frame strobes and gpio pin levels
`timescale 1ns/100ps
`default_nettype none
module ptp_mac_model
  import ptp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // requests from the bench
  input wire ptp_msg_t req,
  input wire logic [1:0] ext_lvl,
  // device side
  output ptp_msg_t msg_in,
  input wire logic [1:0] gpio_o,
  input wire logic [1:0] gpio_oe_n,
  output logic [1:0] gpio_i
);
  // one-cycle strobe at the timestamp point
  always_ff @(posedge core_clk) begin
    msg_in <= req;
  end
  // wire level: device wins while its enable is low
  assign gpio_i = (gpio_oe_n & ext_lvl) | (~gpio_oe_n & gpio_o);
endmodule
`default_nettype wire

// ### ptp_clock_ts_test.sv
// self-checking bench for the ptp clock and timestamp unit
`timescale 1ns/100ps
`default_nettype none
module ptp_clock_ts_test
  import ptp_pkg::*;
;
  logic core_clk = 1'b0, srst = 1'b1, tune_en = 1'b0, time_load = 1'b0, one_step = 1'b0, bad, irq;
  logic [7:0] tune_ns = 8'h0;
  logic [15:0] tune_frac = 16'h0;
  ptp_time_t load_val = '0, now_s, time_now, tgt [2], cap [2];
  logic [1:0] arm = 2'h0, disarm = 2'h0, cfg_in = 2'h0, cfg_rise = 2'h0, cfg_fall = 2'h0, ext = 2'h0;
  logic [1:0] armed, go, goe, gi;
  ptp_gpo_t gout [2];
  ptp_role_t role = PTP_ROLE_RECV;
  ptp_dly_t dly = PTP_DLY_E2E;
  ptp_msg_t req = '0, msg_in;
  ptp_ts_t ts;
  ptp_ins_t ins;
  logic [5:0] mask = 6'h3F, clr = 6'h0, st;
  logic e;
  int n_mismatch = 0, num_checks = 0;

  // device and far side
  ptp_clock_ts #(.PULSE_CYC(2)) u_ptp_clock_ts (.core_clk(core_clk), .srst(srst), .tune_en(tune_en),
    .tune_ns(tune_ns), .tune_frac(tune_frac), .time_load(time_load), .time_load_val(load_val),
    .time_now(time_now), .cmp_target(tgt), .cmp_arm(arm), .cmp_disarm(disarm), .cmp_armed(armed),
    .gpio_cfg_in(cfg_in), .gpio_cfg_rise(cfg_rise), .gpio_cfg_fall(cfg_fall), .gpio_cfg_out(gout),
    .gpio_i(gi), .gpio_o(go), .gpio_oe_n(goe), .gpio_cap_time(cap), .cfg_role(role), .cfg_dly(dly),
    .cfg_one_step(one_step), .msg_in(msg_in), .ts_out(ts), .ins_out(ins), .msg_bad(bad),
    .irq_mask(mask), .irq_clr(clr), .irq_status(st), .irq(irq));
  ptp_mac_model u_ptp_mac_model (.core_clk(core_clk), .req(req), .ext_lvl(ext), .msg_in(msg_in),
    .gpio_o(go), .gpio_oe_n(goe), .gpio_i(gi));

  // 20 mhz clock
  always #25 core_clk = ~core_clk;

  // ************************************************
  // helpers
  // ************************************************
  task automatic check(input logic [67:0] seen, input logic [67:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic load(input ptp_time_t v);
    load_val = v;
    time_load = 1'b1;
    tick(1);
    time_load = 1'b0;
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // whether a message gets a stamp for this role and delay mode
  function automatic logic f_stamp(input logic r, input logic d, input logic t, input logic [3:0] m);
    case (m)
      4'h0: return t == r;
      4'h1: return !d && t != r;
      4'h2, 4'h3: return d;
      default: return 1'b0;
    endcase
  endfunction

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_clock;
    check(time_now, 62'h0);
    tick(1);
    check(time_now, {32'h0, 30'h32});
    load({32'h5, 30'h3B9AC9F6});
    check(time_now, {32'h5, 30'h3B9AC9F6});
    tick(1);
    check(time_now, {32'h6, 30'h28});
    load({32'h7, 30'h3FFFFFFF});
    check(time_now, {32'h7, 30'h0});
    tune_ns = 8'h03;
    tune_frac = 16'h8000;
    tune_en = 1'b1;
    tick(2);
    check(time_now, {32'h7, 30'h7});
    tune_en = 1'b0;
  endtask
  task automatic t_cmp;
    load({32'h1, 30'h0});
    tgt[0] = {32'h1, 30'h64};
    tgt[1] = tgt[0];
    gout[0] = PTP_GO_TOGGLE;
    gout[1] = PTP_GO_PULSE;
    tick(4);
    check(st, 6'h0);
    arm = 2'h3;
    tick(1);
    arm = 2'h0;
    check(armed, 2'h3);
    for (int i = 0; i < 40 && st[0] !== 1'b1; i++) tick(1);
    check({st, irq, armed, go}, {6'h3, 1'b1, 2'h0, 2'h3});
    tick(1);
    check(go[1], 1'b1);
    tick(1);
    check(go[1], 1'b0);
    gout[0] = PTP_GO_IRQ;
    tick(1);
    check(go[0], 1'b1);
    clr = 6'h3;
    tick(1);
    clr = 6'h0;
    check({st, irq}, 7'h0);
    tick(1);
    check(go[0], 1'b0);
    mask = 6'h3C;
    arm = 2'h1;
    tick(1);
    arm = 2'h0;
    tick(2);
    check({st[0], irq}, 2'h2);
    mask = 6'h3F;
    tick(1);
    check(irq, 1'b1);
    clr = 6'h3F;
    tick(1);
    clr = 6'h0;
    tgt[1] = {32'hFFFFFFFF, 30'h0};
    arm = 2'h2;
    tick(1);
    arm = 2'h0;
    check(armed, 2'h2);
    disarm = 2'h2;
    tick(1);
    disarm = 2'h0;
    check(armed, 2'h0);
  endtask
  task automatic t_cap;
    cfg_in = 2'h3;
    cfg_rise = 2'h1;
    cfg_fall = 2'h2;
    tick(1);
    check(goe, 2'h3);
    ext = 2'h1;
    now_s = time_now;
    tick(1);
    check(cap[0], now_s);
    ext = 2'h3;
    tick(1);
    check(st[3:2], 2'h1);
    ext = 2'h1;
    now_s = time_now;
    tick(1);
    check(cap[1], now_s);
    tick(1);
    check(st[3], 1'b1);
    cfg_in = 2'h0;
    clr = 6'h3F;
    tick(1);
    clr = 6'h0;
  endtask
  task automatic t_frame;
    for (int r = 0; r < 2; r++) begin
      for (int d = 0; d < 2; d++) begin
        for (int t = 0; t < 2; t++) begin
          for (int m = 0; m < 16; m++) begin
            role = ptp_role_t'(r[0]);
            dly = ptp_dly_t'(d[0]);
            one_step = d[0];
            req = {1'b1, t[0], m[3:0]};
            tick(1);
            req = '0;
            now_s = time_now;
            tick(1);
            e = f_stamp(r[0], d[0], t[0], m[3:0]);
            check({ts.valid, ins.valid, bad}, {e, e & t[0] & d[0] & (m == 0 || m == 3),
              !(m inside {[0:3], [8:13]})});
            if (e) check({ts.tx, ts.mtype, ts.stamp}, {t[0], m[3:0], now_s});
            if (ins.valid === 1'b1) check(ins.stamp, now_s);
          end
        end
      end
    end
    check(st[5:4], 2'h3);
  endtask

  // reset, then the scenarios in order
  initial begin
    tgt[0] = '0;
    tgt[1] = '0;
    gout[0] = PTP_GO_LOW;
    gout[1] = PTP_GO_LOW;
    repeat (2) @(posedge core_clk);
    #1;
    srst = 1'b0;
    t_clock;
    t_cmp;
    t_cap;
    t_frame;
    summarize;
  end

  // watchdog against a hang
  initial begin
    #(50 * 3000);
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
